// File: mss_map_if.sv
// interface: active channel to relay unit and terminal pair
`timescale 1ns/1ps
interface mss_map_if;
  logic [mss_pkg::CH_W-1:0] channel;
  logic two_wire;
  logic unit;
  logic [mss_pkg::TERM_W-1:0] term;
  modport src (output channel, two_wire, input unit, term);
  modport map (input channel, two_wire, output unit, term);
endinterface

// File: mss_meas_model.sv
// measurement engine model: done pulse per start, slow back emf decay
`timescale 1ns/1ps
module mss_meas_model (
  input wire logic clk_in, // system clock
  input wire logic start_in, // start pulse
  input wire logic fail_in, // judgment to report
  output logic done_out, // done pulse
  output logic fail_out, // judgment, valid with done only
  output logic [31:0] value_out, // measured value
  output logic emf_ok_out // back emf decayed
);
  int cnt = 0;
  int hold = 0;
  assign value_out = 32'h0000_1234;
  initial done_out = 0;
  initial fail_out = 0;
  initial emf_ok_out = 1;
  // emf stays low after each done so the switch really has to wait
  always @(posedge clk_in) begin
    done_out <= (cnt == 1);
    fail_out <= fail_in && (cnt == 1);
    emf_ok_out <= (cnt == 0 && hold == 0);
    hold <= (cnt == 1) ? 6 : (hold > 0 ? hold - 1 : 0);
    cnt <= start_in ? 5 : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule // mss_meas_model

// File: mss_pkg.sv
// package: register map, reset values, timing and state encodings of the scan sequencer
package mss_pkg;
  localparam int CH_W = 6;
  localparam int TERM_W = 5;
  localparam int CTRL_W = 10;
  localparam int IRQ_W = 4;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHEN_LO = 8'h04;
  localparam logic [7:0] OFS_CHEN_HI = 8'h08;
  localparam logic [7:0] OFS_CHSEL = 8'h0C;
  localparam logic [7:0] OFS_RANGE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_RESULT = 8'h24;
  localparam logic [7:0] OFS_GO = 8'h28;
  // ----------------------------------------
  // control fields and reset values
  // ----------------------------------------
  localparam int B_MODE = 0;
  localparam int B_RELAY = 2;
  localparam int B_TWO = 3;
  localparam int B_FSTOP = 4;
  localparam int B_EXT = 5;
  localparam int B_CC = 6;
  localparam int B_SORT = 7;
  localparam int B_STATS = 8;
  localparam int B_MEM = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h002;
  localparam logic [63:0] CHEN_RST = 64'h0000_0000_0000_0001;
  localparam logic [3:0] RANGE_RST = 4'h5;
  localparam logic [3:0] RANGE_LIMIT = 4'h3;
  localparam int IRQ_END = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_HALT = 2;
  localparam int IRQ_REFUSE = 3;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int PAIRS_4W = 10;
  localparam int PAIRS_2W = 21;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 50;
  localparam int END_NS = 5000;
  localparam int END_CYC = (END_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {SCAN_OFF = 2'h0, SCAN_STEP = 2'h1, SCAN_AUTO = 2'h2} mss_scan_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MEAS = 4'h2,
    ST_SWITCH = 4'h4,
    ST_END = 4'h8
  } mss_state_t;
endpackage

// File: mss_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module mss_sync #(
  parameter int W = 1 // bits synchronised
) (
  input logic clk_in, // system clock
  input logic reset_in, // synchronous, active high
  input logic [W-1:0] d_in, // asynchronous pins
  output logic [W-1:0] q_out // synchronised copy
);
  logic [W-1:0] meta;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta <= {W{1'h0}};
      q_out <= {W{1'h0}};
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule // mss_sync

// File: mss_term_map.sv
// channel to unit and terminal pair mapping, by measurement method
`timescale 1ns/1ps
module mss_term_map #(
  parameter int P4 = mss_pkg::PAIRS_4W, // pairs per unit, 4-wire
  parameter int P2 = mss_pkg::PAIRS_2W // pairs per unit, 2-wire
) (
  mss_map_if.map m // channel in, unit and pair out
);
  import mss_pkg::*;
  int pairs;
  int ch;
  always_comb begin
    pairs = m.two_wire ? P2 : P4;
    ch = int'(m.channel);
    if (ch < pairs) begin
      m.unit = 1'h0;
      m.term = TERM_W'(ch);
    end else if (ch < 2 * pairs) begin
      m.unit = 1'h1;
      m.term = TERM_W'(ch - pairs);
    end else begin
      // spare channels default to the first pair of unit zero
      m.unit = 1'h0;
      m.term = {TERM_W{1'h0}};
    end
  end
endmodule // mss_term_map

// File: mss_top.sv
// scan sequencer top: AXI4-Lite registers, scan state machine, mode restrictions
// Function
// - scan off: channel changes only by command or channel-select strobe
// - scan off: each trigger measures current channel, judges, raises end signal
// - step: each trigger measures one channel, then advances in order
// - step: judgment and end signal given before next trigger is taken
// - step: after last channel also give total, whose judgment covers only the last channel
// - auto: one trigger measures all channels, one total and end signal
// - per-channel results on control port only in off and step modes
// - relay terminal mode disables sorting, statistics and data memory
// - relay terminal mode routes front terminals to switch network
// - two-wire relay mode refuses ranges of ten ohms and below
// - two-wire relay mode forces contact check off
// - hold channel change until back EMF has decayed
// - channel to terminal pair map depends on 2-wire or 4-wire
// - while scanning, only the external trigger starts measurements
// - fail-stop halts scan on a fail judgment; default continues
`timescale 1ns/1ps
module mss_top #(
  parameter int NCH = 42, // channels, at most 64
  parameter int END_CYCLES = mss_pkg::END_CYC // least end-signal hold
) (
  input logic clk_in, // 20 MHz clock
  input logic reset_in, // synchronous, active high
  input logic [7:0] s_axi_awaddr_in, // write address
  input logic s_axi_awvalid_in, // write address valid
  output logic s_axi_awready_out, // write address ready
  input logic [31:0] s_axi_wdata_in, // write data
  input logic [3:0] s_axi_wstrb_in, // byte strobes
  input logic s_axi_wvalid_in, // write data valid
  output logic s_axi_wready_out, // write data ready
  output logic [1:0] s_axi_bresp_out, // write response
  output logic s_axi_bvalid_out, // write response valid
  input logic s_axi_bready_in, // write response ready
  input logic [7:0] s_axi_araddr_in, // read address
  input logic s_axi_arvalid_in, // read address valid
  output logic s_axi_arready_out, // read address ready
  output logic [31:0] s_axi_rdata_out, // read data
  output logic [1:0] s_axi_rresp_out, // read response
  output logic s_axi_rvalid_out, // read data valid
  input logic s_axi_rready_in, // read data ready
  input logic measure_trigger_input_in, // trigger pin, rising edge
  input logic chan_strobe_in, // channel-select strobe pin, rising edge
  input logic [mss_pkg::CH_W-1:0] chan_code_in, // channel number pins
  input logic emf_decayed_in, // back EMF below limit, level pin
  input logic meas_done_in, // measurement finished, pulse
  input logic meas_fail_in, // judgment with done: 1 fail
  input logic [31:0] meas_value_in, // measured value with done
  output logic meas_start_out, // start one measurement, pulse
  output logic [mss_pkg::CH_W-1:0] relay_channel_out, // active channel
  output logic relay_unit_out, // relay unit of active channel
  output logic [mss_pkg::TERM_W-1:0] relay_term_out, // terminal pair
  output logic front_term_to_switch_out, // front terminals to relays
  output logic end_of_measure_signal_out, // end of measurement level
  output logic total_valid_out, // total judgment available
  output logic total_fail_out, // total judgment: 1 fail
  output logic external_control_port_valid_out, // channel result valid
  output logic external_control_port_fail_out, // channel judgment
  output logic [mss_pkg::CH_W-1:0] external_control_port_channel_out, // result channel
  output logic sort_en_out, // bin sort function allowed
  output logic stats_en_out, // statistics allowed
  output logic memory_en_out, // data memory allowed
  output logic contact_check_en_out, // contact check enabled
  output logic [3:0] range_out, // accepted range code
  output logic irq_out // interrupt level
);
  import mss_pkg::*;
  localparam int SW = 3 + CH_W;
  localparam int END_W = $clog2(END_CYCLES + 1);

  // ----------------------------------------
  // synchronised pins
  // ----------------------------------------
  logic [SW-1:0] pin_s;
  logic measure_trigger_input_s, strobe_s, emf_s, measure_trigger_input_d, strobe_d, ext_edge, strobe_edge;
  logic [CH_W-1:0] code_s;
  mss_sync #(.W(SW)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .d_in({measure_trigger_input_in, chan_strobe_in, emf_decayed_in, chan_code_in}),
    .q_out(pin_s)
  );
  assign {measure_trigger_input_s, strobe_s, emf_s, code_s} = pin_s;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      measure_trigger_input_d <= 1'h0;
      strobe_d <= 1'h0;
    end else begin
      measure_trigger_input_d <= measure_trigger_input_s;
      strobe_d <= strobe_s;
    end
  end
  assign ext_edge = measure_trigger_input_s && !measure_trigger_input_d;
  assign strobe_edge = strobe_s && !strobe_d;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_full, w_full, bvalid, rvalid, wr_fire;
  logic [7:0] aw_addr;
  logic [31:0] w_data, rdata, rd_word;
  logic [3:0] w_strb;
  logic [1:0] bresp, rresp;
  assign s_axi_awready_out = !aw_full;
  assign s_axi_wready_out = !w_full;
  assign s_axi_arready_out = !rvalid;
  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = bresp;
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out = rdata;
  assign s_axi_rresp_out = rresp;
  assign wr_fire = aw_full && w_full && !bvalid;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[7:2] <= OFS_GO[7:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    for (int b = 0; b < 4; b++) r[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    return r;
  endfunction

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      aw_full <= 1'h0;
      w_full <= 1'h0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'h0;
      bresp <= RESP_OK;
    end else begin
      if (s_axi_awvalid_in && !aw_full) begin
        aw_full <= 1'h1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_full) begin
        w_full <= 1'h1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_full <= 1'h0;
        w_full <= 1'h0;
        bvalid <= 1'h1;
        bresp <= mapped(aw_addr) ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready_in) begin
        bvalid <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rvalid <= 1'h0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OK;
    end else if (s_axi_arvalid_in && !rvalid) begin
      rvalid <= 1'h1;
      rdata <= rd_word;
      rresp <= mapped(s_axi_araddr_in) ? RESP_OK : RESP_ERR;
    end else if (s_axi_rready_in) begin
      rvalid <= 1'h0;
    end
  end

  // ----------------------------------------
  // registers and mode decode
  // ----------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [63:0] chen;
  logic [3:0] range_code;
  logic [IRQ_W-1:0] irq_stat, irq_en, irq_ev, irq_clr;
  logic [31:0] last_value;
  logic last_fail, relay_mode, two_mode, is_step, is_auto, scanning;
  logic rng_wr, refuse, soft_go, sel_wr, measure_trigger_input_go;
  mss_scan_t mode;
  assign relay_mode = ctrl[B_RELAY];
  assign two_mode = relay_mode && ctrl[B_TWO];
  assign mode = mss_scan_t'(ctrl[B_MODE +: 2]);
  assign is_step = relay_mode && mode == SCAN_STEP;
  assign is_auto = relay_mode && mode == SCAN_AUTO;
  assign scanning = is_step || is_auto;
  assign rng_wr = wr_fire && hit(aw_addr, OFS_RANGE) && w_strb[0];
  assign refuse = rng_wr && two_mode && w_data[3:0] <= RANGE_LIMIT;
  assign soft_go = wr_fire && hit(aw_addr, OFS_GO) && w_strb[0] && w_data[0];
  assign sel_wr = wr_fire && hit(aw_addr, OFS_CHSEL) && w_strb[0];
  assign irq_clr = (wr_fire && hit(aw_addr, OFS_IRQ_CLR)) ? w_data[IRQ_W-1:0] : 4'h0;
  // software start is ignored while scanning so a stray write cannot skip the handler
  assign measure_trigger_input_go = (scanning || ctrl[B_EXT]) ? ext_edge : soft_go;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl <= CTRL_RST;
      chen <= CHEN_RST;
      range_code <= RANGE_RST;
      irq_en <= 4'h0;
      irq_stat <= 4'h0;
    end else begin
      if (wr_fire && hit(aw_addr, OFS_CTRL)) begin
        ctrl <= CTRL_W'(merge(32'(ctrl), w_data, w_strb));
      end
      if (wr_fire && hit(aw_addr, OFS_CHEN_LO)) begin
        chen[31:0] <= merge(chen[31:0], w_data, w_strb);
      end
      if (wr_fire && hit(aw_addr, OFS_CHEN_HI)) begin
        chen[63:32] <= merge(chen[63:32], w_data, w_strb);
      end
      if (wr_fire && hit(aw_addr, OFS_IRQ_EN) && w_strb[0]) begin
        irq_en <= w_data[IRQ_W-1:0];
      end
      if (rng_wr && !refuse) begin
        range_code <= w_data[3:0];
      end
      // a new event wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
    end
  end

  // ----------------------------------------
  // scan sequencer
  // ----------------------------------------
  mss_state_t state, after_sw;
  logic [CH_W-1:0] cur_ch, target, nxt, first;
  logic [END_W-1:0] end_cnt;
  logic halted, tot_fail, end_of_measure_signal, stop_now, last_now, done_now;

  // next enabled channel after 'from', wrapping; stays put if none is enabled
  function automatic logic [CH_W-1:0] next_en(input logic [63:0] en, input logic [CH_W-1:0] from);
    logic [CH_W-1:0] r;
    int j;
    r = from;
    for (int i = NCH; i >= 1; i--) begin
      j = (int'(from) + i) % NCH;
      if (en[j]) r = CH_W'(j);
    end
    return r;
  endfunction

  assign nxt = next_en(chen, cur_ch);
  assign first = next_en(chen, CH_W'(NCH - 1));
  assign done_now = state == ST_MEAS && meas_done_in;
  assign stop_now = scanning && ctrl[B_FSTOP] && meas_fail_in;
  assign last_now = nxt <= cur_ch;
  assign irq_ev = {refuse, done_now && stop_now, done_now && meas_fail_in,
                   state == ST_END && !end_of_measure_signal};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
      after_sw <= ST_IDLE;
      cur_ch <= {CH_W{1'h0}};
      target <= {CH_W{1'h0}};
      end_cnt <= {END_W{1'h0}};
      halted <= 1'h0;
      tot_fail <= 1'h0;
      end_of_measure_signal <= 1'h0;
      meas_start_out <= 1'h0;
      total_valid_out <= 1'h0;
      total_fail_out <= 1'h0;
    end else begin
      meas_start_out <= 1'h0;
      case (state)
        ST_IDLE: begin
          if (measure_trigger_input_go) begin
            end_of_measure_signal <= 1'h0;
            halted <= 1'h0;
            total_valid_out <= 1'h0;
            tot_fail <= 1'h0;
            if (is_auto && cur_ch != first) begin
              target <= first;
              after_sw <= ST_MEAS;
              state <= ST_SWITCH;
            end else begin
              meas_start_out <= 1'h1;
              state <= ST_MEAS;
            end
          end else if (!scanning && strobe_edge) begin
            target <= code_s;
            after_sw <= ST_IDLE;
            state <= ST_SWITCH;
          end else if (!scanning && sel_wr) begin
            target <= w_data[CH_W-1:0];
            after_sw <= ST_IDLE;
            state <= ST_SWITCH;
          end
        end
        ST_MEAS: begin
          if (meas_done_in) begin
            tot_fail <= tot_fail || meas_fail_in;
            if (!scanning) begin
              state <= ST_END;
            end else begin
              state <= ST_SWITCH;
              if (stop_now || last_now) begin
                target <= first;
                after_sw <= ST_END;
                total_valid_out <= 1'h1;
                total_fail_out <= tot_fail || meas_fail_in;
                halted <= stop_now;
              end else begin
                target <= nxt;
                after_sw <= is_auto ? ST_MEAS : ST_END;
              end
            end
          end
        end
        ST_SWITCH: begin
          // relays must not open while the current channel still drives current
          if (emf_s) begin
            cur_ch <= target;
            state <= after_sw;
            meas_start_out <= after_sw == ST_MEAS;
          end
        end
        ST_END: begin
          end_of_measure_signal <= 1'h1;
          end_cnt <= end_cnt + 1'h1;
          if (end_cnt == END_W'(END_CYCLES - 1)) begin
            end_cnt <= {END_W{1'h0}};
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  assign end_of_measure_signal_out = end_of_measure_signal;

  // ----------------------------------------
  // results, control port and restrictions
  // ----------------------------------------
  mss_map_if map_if();
  assign map_if.channel = cur_ch;
  assign map_if.two_wire = ctrl[B_TWO];
  mss_term_map u_map (
    .m(map_if)
  );

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      last_value <= 32'h0000_0000;
      last_fail <= 1'h0;
      external_control_port_valid_out <= 1'h0;
      external_control_port_fail_out <= 1'h0;
      external_control_port_channel_out <= {CH_W{1'h0}};
    end else begin
      if (done_now) begin
        last_value <= meas_value_in;
        last_fail <= meas_fail_in;
      end
      if (is_auto) begin
        external_control_port_valid_out <= 1'h0;
      end else if (done_now) begin
        external_control_port_valid_out <= 1'h1;
        external_control_port_fail_out <= meas_fail_in;
        external_control_port_channel_out <= cur_ch;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      relay_channel_out <= {CH_W{1'h0}};
      relay_unit_out <= 1'h0;
      relay_term_out <= {TERM_W{1'h0}};
      front_term_to_switch_out <= 1'h0;
      sort_en_out <= 1'h0;
      stats_en_out <= 1'h0;
      memory_en_out <= 1'h0;
      contact_check_en_out <= 1'h0;
      range_out <= RANGE_RST;
      irq_out <= 1'h0;
    end else begin
      relay_channel_out <= cur_ch;
      relay_unit_out <= map_if.unit;
      relay_term_out <= map_if.term;
      front_term_to_switch_out <= relay_mode;
      sort_en_out <= ctrl[B_SORT] && !relay_mode;
      stats_en_out <= ctrl[B_STATS] && !relay_mode;
      memory_en_out <= ctrl[B_MEM] && !relay_mode;
      contact_check_en_out <= ctrl[B_CC] && !two_mode;
      range_out <= range_code;
      irq_out <= |(irq_stat & irq_en);
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr_in[7:2])
      OFS_CTRL[7:2]: rd_word = 32'(ctrl);
      OFS_CHEN_LO[7:2]: rd_word = chen[31:0];
      OFS_CHEN_HI[7:2]: rd_word = chen[63:32];
      OFS_CHSEL[7:2]: rd_word = 32'(cur_ch);
      OFS_RANGE[7:2]: rd_word = 32'(range_code);
      OFS_STATUS[7:2]: rd_word = {12'h000, contact_check_en_out, memory_en_out, stats_en_out,
                                  sort_en_out, last_fail, end_of_measure_signal, emf_s, halted, state, 2'h0,
                                  cur_ch};
      OFS_IRQ_STAT[7:2]: rd_word = 32'(irq_stat);
      OFS_IRQ_EN[7:2]: rd_word = 32'(irq_en);
      OFS_RESULT[7:2]: rd_word = last_value;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  off_start_a: assert property (
    state == ST_IDLE && measure_trigger_input_go && !scanning |=> meas_start_out && state == ST_MEAS)
    else $error("scan off trigger did not start a measurement");
  scan_src_a: assert property (
    state == ST_IDLE && scanning && !ext_edge |=> !meas_start_out && state == ST_IDLE)
    else $error("measurement started without external trigger while scanning");
  chan_cause_a: assert property (
    $changed(cur_ch) |-> $past(state) == ST_SWITCH && $past(emf_s))
    else $error("channel changed outside a settled switch");
  emf_hold_a: assert property (
    state == ST_SWITCH && !emf_s |=> $stable(cur_ch) && state == ST_SWITCH)
    else $error("channel switched before back EMF decayed");
  end_first_a: assert property (
    meas_start_out |-> !end_of_measure_signal_out)
    else $error("end signal still high at measurement start");
  auto_one_a: assert property (
    is_auto && state == ST_MEAS |-> !end_of_measure_signal_out && !total_valid_out)
    else $error("auto scan gave end or total mid-scan");
  auto_port_a: assert property (
    is_auto |=> !external_control_port_valid_out)
    else $error("channel result shown on control port in auto scan");
  step_total_a: assert property (
    done_now && is_step && last_now |=> total_valid_out ##0 after_sw == ST_END)
    else $error("last step channel gave no total judgment");
  fail_halt_a: assert property (
    done_now && stop_now |=> halted && total_fail_out && after_sw == ST_END)
    else $error("fail stop did not halt the scan");
  range_lock_a: assert property (
    refuse |=> $stable(range_code) && irq_stat[IRQ_REFUSE])
    else $error("low range accepted in two-wire mode");
  relay_lock_a: assert property (
    relay_mode && $stable(ctrl) |=> !sort_en_out && !stats_en_out && !memory_en_out)
    else $error("sorting, statistics or memory enabled with relay terminals");
  cc_off_a: assert property (
    two_mode && $stable(ctrl) |=> !contact_check_en_out && front_term_to_switch_out)
    else $error("contact check enabled in two-wire relay mode");

  auto_run_c: cover property (state == ST_SWITCH && after_sw == ST_MEAS && emf_s);
  step_total_c: cover property (is_step && $rose(total_valid_out));
  halt_c: cover property ($rose(halted));
  off_sel_c: cover property (!scanning && strobe_edge && state == ST_IDLE);
endmodule // mss_top

// File: tb.sv
// testbench: scan sequencer with register bus and measurement model
`timescale 1ns/1ps
module tb;
  import mss_pkg::*;
  logic clk_in = 0, reset_in = 1, s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
  logic s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
  logic measure_trigger_input_in = 0, chan_strobe_in = 0, fail_req = 0;
  logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, meas_value_in, rd_d;
  logic [3:0] s_axi_wstrb_in = 4'hF, range_out;
  logic [CH_W-1:0] chan_code_in = 0, relay_channel_out, external_control_port_channel_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rd_r, wr_r;
  logic [TERM_W-1:0] relay_term_out;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, emf_decayed_in, meas_done_in, meas_fail_in, meas_start_out;
  logic relay_unit_out, front_term_to_switch_out, end_of_measure_signal_out;
  logic total_valid_out, total_fail_out, external_control_port_valid_out;
  logic external_control_port_fail_out, sort_en_out, stats_en_out, memory_en_out;
  logic contact_check_en_out, irq_out;
  int err_count = 0, tests_run = 0, cyc = 0;
  always #25 clk_in = ~clk_in;
  // short end hold keeps the run brief
  mss_top #(.NCH(8), .END_CYCLES(4)) uut (.*);
  mss_meas_model pm (.clk_in(clk_in), .start_in(meas_start_out), .fail_in(fail_req),
    .done_out(meas_done_in),
    .fail_out(meas_fail_in), .value_out(meas_value_in), .emf_ok_out(emf_decayed_in));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    s_axi_bready_in <= 1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 0;
      n++;
    end while (s_axi_bvalid_out !== 1 && n < 99);
    wr_r = s_axi_bresp_out;
    s_axi_bready_in <= 0;
    @(posedge clk_in);
  endtask
  task rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    s_axi_rready_in <= 1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 0;
      n++;
    end while (s_axi_rvalid_out !== 1 && n < 99);
    rd_d = s_axi_rdata_out;
    rd_r = s_axi_rresp_out;
    s_axi_rready_in <= 0;
    @(posedge clk_in);
  endtask
  // pin pulse long enough for the synchroniser, then wait for the end level
  task measure_trigger_input;
    int n;
    n = 0;
    measure_trigger_input_in <= 1;
    repeat (5) @(posedge clk_in);
    measure_trigger_input_in <= 0;
    while (end_of_measure_signal_out !== 1 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    repeat (8) @(posedge clk_in);
  endtask
  task t_step;
    wr(OFS_CHEN_LO, 32'h5);
    wr(OFS_CTRL, 32'h5);
    measure_trigger_input;
    chk("chan", 2, relay_channel_out);
    chk("port_v", 1, external_control_port_valid_out);
    chk("total_v", 0, total_valid_out);
    measure_trigger_input;
    chk("chan", 0, relay_channel_out);
    chk("port_ch", 2, external_control_port_channel_out);
    chk("total_v", 1, total_valid_out);
    // a software start must not move the scan on
    wr(OFS_GO, 32'h1);
    repeat (20) @(posedge clk_in);
    chk("eom", 1, end_of_measure_signal_out);
    chk("chan", 0, relay_channel_out);
  endtask
  task t_auto;
    wr(OFS_CTRL, 32'h6);
    measure_trigger_input;
    chk("total_v", 1, total_valid_out);
    chk("port_v", 0, external_control_port_valid_out);
    chk("chan", 0, relay_channel_out);
    // every judgment fails from here on; fail stop ends the run after channel 0
    fail_req <= 1;
    wr(OFS_CTRL, 32'h16);
    measure_trigger_input;
    chk("total_f", 1, total_fail_out);
    rd(OFS_STATUS);
    chk("halted", 1, rd_d[12]);
  endtask
  task t_limits;
    wr(OFS_CTRL, 32'h380);
    repeat (3) @(posedge clk_in);
    chk("sort", 1, sort_en_out);
    // code settles a cycle ahead of the strobe edge
    chan_code_in <= 12;
    @(posedge clk_in);
    chan_strobe_in <= 1;
    repeat (5) @(posedge clk_in);
    chan_strobe_in <= 0;
    repeat (8) @(posedge clk_in);
    chk("chan", 12, relay_channel_out);
    chk("map4", 32'h22, {relay_unit_out, relay_term_out});
    wr(OFS_GO, 32'h1);
    repeat (30) @(posedge clk_in);
    chk("eom", 1, end_of_measure_signal_out);
    chk("port_f", 1, external_control_port_fail_out);
    chk("port_ch", 12, external_control_port_channel_out);
    chk("chan", 12, relay_channel_out);
    wr(OFS_CTRL, 32'h3CC);
    wr(OFS_IRQ_EN, 32'h8);
    wr(OFS_RANGE, 32'h3);
    repeat (3) @(posedge clk_in);
    chk("lim", 32'h5, {sort_en_out, stats_en_out, memory_en_out, range_out});
    chk("cc_front", 1, {contact_check_en_out, front_term_to_switch_out});
    chk("map2", 32'hC, {relay_unit_out, relay_term_out});
    chk("irq", 1, irq_out);
    wr(OFS_IRQ_CLR, 32'h8);
    repeat (3) @(posedge clk_in);
    chk("irq", 0, irq_out);
  endtask
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    reset_in <= 0;
    @(posedge clk_in);
    rd(OFS_CTRL);
    chk("ctrl", 32'h2, rd_d);
    rd(8'h40);
    chk("resp", RESP_ERR, rd_r);
    wr(8'h40, 32'h1);
    chk("bresp", RESP_ERR, wr_r);
    t_step;
    t_auto;
    t_limits;
    tally_and_finish;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish;
    end
  end
endmodule // tb
